// ---- verilog/sfr_rule_engine.sv ----
// Functional notes
// - Rule memory holds 2048 words of 32 bits.
// - Two-word descriptors; filter n at word 2n.
// - Rule block is three to nine words.
// - Single-fire filter disables itself after matching.
// - Descriptor word zero fields, reset to zero.
// - Optional port and stream id check.
// - Optional table id check before rules.
// - Rule control word field layout.
// - Mode codes: inside, outside, equal, differ.
// - Inside mode: min <= shifted value <= max.
// - Outside mode: below min or above max.
// - Equal mode: masked header equals masked pattern.
// - Differ mode: any unmasked bit differs.
// - Bit shift used only in bounds modes.
// - Pattern length one to four words.
// - Bounds min then max; coeffs then masks.
// - Follow chain to last; miss fails filter.
// - Stop chain on first miss always.
// - Up to 128 filters in 256 words.
// - Match sets flag and filter index in event.
// - Header bytes arrive low byte first.
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module sfr_rule_engine #(
   parameter int unsigned NUM_FILTERS = 128
) (
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_resetn,
   // Register port
   input  wire logic [11:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata
);
   if (NUM_FILTERS < 1 || NUM_FILTERS > sfr_pkg::SFR_MAX_FILT) begin : g_bad_filters
      $error("NUM_FILTERS must be 1 to 128");
   end

   logic [31:0]         mem_ff [sfr_pkg::SFR_MEM_WORDS];
   logic [31:0]         cmd_ff [sfr_pkg::SFR_PKT_WORDS];
   logic [31:0]         evt_ff [sfr_pkg::SFR_PKT_WORDS];
   logic [3:0]          cmd_cnt_ff;
   logic [3:0]          evt_rd_ff;
   logic                evt_valid_ff;
   logic [127:0]        en_ff;
   logic [7:0]          idx_ff;
   logic [10:0]         ptr_ff;
   logic [31:0]         o_rdata_ff;
   sfr_pkg::sfr_state_t st_ff;
   sfr_pkg::sfr_state_t nxt_st;
   logic [7:0]          nxt_idx;
   logic [10:0]         nxt_ptr;

   logic                cmd_wr;
   logic                evt_pop;
   logic                start;
   logic                pkt_done;
   logic [255:0]        hdr;
   logic [31:0]         desc0;
   logic [31:0]         desc1;
   logic                desc_ok;
   logic [31:0]         ctrl;
   logic [1:0]          mode;
   logic [3:0]          len;
   logic [255:0]        bound_sel;
   logic [255:0]        pat_sel;
   logic [31:0]         lo_word;
   logic [31:0]         hi_word;
   logic [3:0]          word_ok;
   logic                pat_eq;
   logic                rule_hit;
   logic                fire_clear;

   assign o_rdata = o_rdata_ff;

   // Header words 2..9 form 32 bytes, byte 0 in bit 0
   for (genvar k = 0; k < 8; k++) begin : g_hdr
      assign hdr[32*k +: 32] = cmd_ff[sfr_pkg::SFR_HDR_BASE + k];
   end

   // Commands are refused while a packet is pending or in flight
   assign cmd_wr   = i_wr && i_addr == sfr_pkg::SFR_ADDR_CMD && st_ff == sfr_pkg::SFR_S_IDLE
                     && cmd_cnt_ff <= sfr_pkg::SFR_PKT_LAST;
   assign evt_pop  = i_rd && i_addr == sfr_pkg::SFR_ADDR_EVT && evt_valid_ff;
   // Waiting for an empty event slot gives back-pressure to software
   assign start    = st_ff == sfr_pkg::SFR_S_IDLE && cmd_cnt_ff == 4'(sfr_pkg::SFR_PKT_WORDS)
                     && !evt_valid_ff;

   // Descriptor fetch: filter n sits at word 2n
   assign desc0 = mem_ff[11'({idx_ff[6:0], 1'b0})];
   assign desc1 = mem_ff[11'({idx_ff[6:0], 1'b1})];

   always_comb begin
      desc_ok = en_ff[idx_ff[6:0]];
      if (desc0[sfr_pkg::SFR_D0_SIDCHK] &&
          desc1[sfr_pkg::SFR_D1_SID +: 16] != cmd_ff[0][sfr_pkg::SFR_C_SID +: 16]) begin
         desc_ok = 1'b0;
      end
      if (desc0[sfr_pkg::SFR_D0_TBLCHK] &&
          desc1[sfr_pkg::SFR_D1_TBL +: 8] != cmd_ff[0][sfr_pkg::SFR_C_TBL +: 8]) begin
         desc_ok = 1'b0;
      end
   end

   // Rule evaluation in one cycle from the flop memory
   assign ctrl      = mem_ff[ptr_ff];
   assign mode      = ctrl[sfr_pkg::SFR_R_MODE +: 2];
   assign len       = ctrl[sfr_pkg::SFR_R_LEN +: 4];
   assign lo_word   = mem_ff[11'(ptr_ff + 11'h1)];
   assign hi_word   = mem_ff[11'(ptr_ff + 11'h2)];
   // Bounds modes shift by whole bytes plus bits
   assign bound_sel = hdr >> {ctrl[sfr_pkg::SFR_R_BYTE +: 5], ctrl[sfr_pkg::SFR_R_BIT +: 3]};
   // Pattern modes ignore the bit shift
   assign pat_sel   = hdr >> {ctrl[sfr_pkg::SFR_R_BYTE +: 5], 3'h0};

   // Coefficients first, masks after them, len words each
   for (genvar i = 0; i < 4; i++) begin : g_pat
      logic [31:0] coeff;
      logic [31:0] mask;
      assign coeff = mem_ff[11'(ptr_ff + 11'(i + 1))];
      assign mask  = mem_ff[11'(ptr_ff + 11'(i + 1) + {7'h0, len})];
      assign word_ok[i] = (4'(i) >= len) || (((pat_sel[32*i +: 32] ^ coeff) & mask) == 32'h0);
   end
   assign pat_eq = &word_ok;

   always_comb begin
      unique case (mode)
         sfr_pkg::SFR_MODE_INSIDE:
            rule_hit = bound_sel[31:0] >= lo_word && bound_sel[31:0] <= hi_word;
         sfr_pkg::SFR_MODE_OUTSIDE:
            rule_hit = bound_sel[31:0] < lo_word || bound_sel[31:0] > hi_word;
         sfr_pkg::SFR_MODE_EQUAL:
            rule_hit = len >= sfr_pkg::SFR_LEN_MIN && len <= sfr_pkg::SFR_LEN_MAX && pat_eq;
         sfr_pkg::SFR_MODE_DIFFER:
            rule_hit = len >= sfr_pkg::SFR_LEN_MIN && len <= sfr_pkg::SFR_LEN_MAX && !pat_eq;
      endcase
   end

   // Main sequence
   always_comb begin
      nxt_st  = st_ff;
      nxt_idx = idx_ff;
      nxt_ptr = ptr_ff;
      unique case (st_ff)
         sfr_pkg::SFR_S_IDLE: begin
            if (start) begin
               nxt_st  = sfr_pkg::SFR_S_FILT;
               nxt_idx = 8'h0;
            end
         end
         sfr_pkg::SFR_S_FILT: begin
            if (idx_ff >= 8'(NUM_FILTERS)) begin
               nxt_st = sfr_pkg::SFR_S_IDLE;
            end else if (desc_ok) begin
               nxt_st  = sfr_pkg::SFR_S_RULE;
               nxt_ptr = desc0[sfr_pkg::SFR_D0_PTR +: 11];
            end else begin
               nxt_idx = 8'(idx_ff + 8'h1);
            end
         end
         sfr_pkg::SFR_S_RULE: begin
            // Halt flag is not consulted: any miss ends the chain
            if (!rule_hit) begin
               nxt_st  = sfr_pkg::SFR_S_FILT;
               nxt_idx = 8'(idx_ff + 8'h1);
            end else if (ctrl[sfr_pkg::SFR_R_LAST]) begin
               nxt_st = sfr_pkg::SFR_S_EMIT;
            end else begin
               nxt_ptr = ctrl[sfr_pkg::SFR_R_NEXT +: 11];
            end
         end
         sfr_pkg::SFR_S_EMIT: begin
            nxt_st = sfr_pkg::SFR_S_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_ff  <= sfr_pkg::SFR_S_IDLE;
         idx_ff <= 8'h0;
         ptr_ff <= 11'h0;
      end else begin
         st_ff  <= nxt_st;
         idx_ff <= nxt_idx;
         ptr_ff <= nxt_ptr;
      end
   end

   assign pkt_done   = st_ff == sfr_pkg::SFR_S_EMIT ||
                       (st_ff == sfr_pkg::SFR_S_FILT && idx_ff >= 8'(NUM_FILTERS));
   assign fire_clear = st_ff == sfr_pkg::SFR_S_EMIT && desc0[sfr_pkg::SFR_D0_SINGLE];

   // Rule memory, written only by software
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         for (int m = 0; m < sfr_pkg::SFR_MEM_WORDS; m++) begin
            mem_ff[m] <= 32'h0;
         end
      end else if (i_wr && !i_addr[11]) begin
         mem_ff[i_addr[10:0]] <= i_wdata;
      end
   end

   // Command staging
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cmd_cnt_ff <= 4'h0;
         for (int c = 0; c < sfr_pkg::SFR_PKT_WORDS; c++) begin
            cmd_ff[c] <= 32'h0;
         end
      end else if (pkt_done) begin
         cmd_cnt_ff <= 4'h0;
      end else if (cmd_wr) begin
         cmd_ff[cmd_cnt_ff] <= i_wdata;
         cmd_cnt_ff         <= 4'(cmd_cnt_ff + 4'h1);
      end
   end

   // Event slot: copy of the command with result fields updated
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         evt_valid_ff <= 1'b0;
         evt_rd_ff    <= 4'h0;
         for (int e = 0; e < sfr_pkg::SFR_PKT_WORDS; e++) begin
            evt_ff[e] <= 32'h0;
         end
      end else if (st_ff == sfr_pkg::SFR_S_EMIT) begin
         for (int e = 0; e < sfr_pkg::SFR_PKT_WORDS; e++) begin
            evt_ff[e] <= cmd_ff[e];
         end
         evt_ff[0][sfr_pkg::SFR_C_MATCH]    <= 1'b1;
         evt_ff[0][sfr_pkg::SFR_C_FLT +: 7] <= idx_ff[6:0];
         evt_valid_ff <= 1'b1;
         evt_rd_ff    <= 4'h0;
      end else if (evt_pop) begin
         evt_rd_ff <= 4'(evt_rd_ff + 4'h1);
         if (evt_rd_ff == sfr_pkg::SFR_PKT_LAST) begin
            evt_valid_ff <= 1'b0;
            evt_rd_ff    <= 4'h0;
         end
      end
   end

   // Filter enables; a software write in the clear cycle wins
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         en_ff <= 128'h0;
      end else begin
         for (int f = 0; f < sfr_pkg::SFR_MAX_FILT; f++) begin
            if (i_wr && i_addr == 12'(sfr_pkg::SFR_ADDR_EN0 + 12'(f / 32))) begin
               en_ff[f] <= i_wdata[f % 32] && f < NUM_FILTERS;
            end else if (fire_clear && idx_ff[6:0] == 7'(f)) begin
               en_ff[f] <= 1'b0;
            end
         end
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_rdata_ff <= 32'h0;
      end else if (i_rd) begin
         o_rdata_ff <= 32'h0;
         if (!i_addr[11]) begin
            o_rdata_ff <= mem_ff[i_addr[10:0]];
         end else if (i_addr == sfr_pkg::SFR_ADDR_EVT && evt_valid_ff) begin
            o_rdata_ff <= evt_ff[evt_rd_ff];
         end else if (i_addr == sfr_pkg::SFR_ADDR_STAT) begin
            o_rdata_ff[sfr_pkg::SFR_ST_BUSY]       <= st_ff != sfr_pkg::SFR_S_IDLE;
            o_rdata_ff[sfr_pkg::SFR_ST_EVT]        <= evt_valid_ff;
            o_rdata_ff[sfr_pkg::SFR_ST_STATE +: 2] <= st_ff;
            o_rdata_ff[sfr_pkg::SFR_ST_IDX +: 8]   <= idx_ff;
            o_rdata_ff[sfr_pkg::SFR_ST_PTR +: 11]  <= ptr_ff;
         end else begin
            for (int w = 0; w < sfr_pkg::SFR_EN_WORDS; w++) begin
               if (i_addr == 12'(sfr_pkg::SFR_ADDR_EN0 + 12'(w))) begin
                  o_rdata_ff <= en_ff[32*w +: 32];
               end
            end
         end
      end
   end

   // Checks
   property p_single_fire;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_EMIT && desc0[sfr_pkg::SFR_D0_SINGLE] && !i_wr)
         |=> !en_ff[$past(idx_ff[6:0])];
   endproperty
   a_single_fire: assert property (p_single_fire) else $error("single-fire filter still on");

   property p_event_index;
      @(posedge i_clk) disable iff (!i_resetn)
      st_ff == sfr_pkg::SFR_S_EMIT |=> evt_valid_ff && evt_ff[0][sfr_pkg::SFR_C_MATCH]
         && evt_ff[0][sfr_pkg::SFR_C_FLT +: 7] == $past(idx_ff[6:0]) && st_ff == sfr_pkg::SFR_S_IDLE;
   endproperty
   a_event_index: assert property (p_event_index) else $error("event word wrong after match");

   property p_start_first;
      @(posedge i_clk) disable iff (!i_resetn)
      start |=> st_ff == sfr_pkg::SFR_S_FILT && idx_ff == 8'h0;
   endproperty
   a_start_first: assert property (p_start_first) else $error("scan did not start at filter 0");

   property p_miss_next;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_RULE && !rule_hit)
         |=> st_ff == sfr_pkg::SFR_S_FILT && idx_ff == 8'($past(idx_ff) + 8'h1);
   endproperty
   a_miss_next: assert property (p_miss_next) else $error("miss did not end the chain");

   property p_chain_follow;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_RULE && rule_hit && !ctrl[sfr_pkg::SFR_R_LAST])
         |=> st_ff == sfr_pkg::SFR_S_RULE && ptr_ff == $past(ctrl[sfr_pkg::SFR_R_NEXT +: 11]);
   endproperty
   a_chain_follow: assert property (p_chain_follow) else $error("next rule not followed");

   property p_skip_disabled;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_FILT && idx_ff < 8'(NUM_FILTERS) && !en_ff[idx_ff[6:0]])
         |=> st_ff == sfr_pkg::SFR_S_FILT && idx_ff == 8'($past(idx_ff) + 8'h1);
   endproperty
   a_skip_disabled: assert property (p_skip_disabled) else $error("disabled filter applied");

   property p_discard;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_FILT && idx_ff >= 8'(NUM_FILTERS))
         |=> st_ff == sfr_pkg::SFR_S_IDLE && !evt_valid_ff && cmd_cnt_ff == 4'h0;
   endproperty
   a_discard: assert property (p_discard) else $error("unmatched packet not discarded");

   property p_id_check;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_FILT && idx_ff < 8'(NUM_FILTERS) && desc0[sfr_pkg::SFR_D0_SIDCHK]
         && desc1[sfr_pkg::SFR_D1_SID +: 16] != cmd_ff[0][sfr_pkg::SFR_C_SID +: 16]) |=> st_ff != sfr_pkg::SFR_S_RULE;
   endproperty
   a_id_check: assert property (p_id_check) else $error("id mismatch entered rules");

   property p_rule_enter;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_FILT && idx_ff < 8'(NUM_FILTERS) && desc_ok)
         |=> st_ff == sfr_pkg::SFR_S_RULE && ptr_ff == $past(desc0[sfr_pkg::SFR_D0_PTR +: 11]);
   endproperty
   a_rule_enter: assert property (p_rule_enter) else $error("first rule pointer not loaded");

   property p_len_guard;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff == sfr_pkg::SFR_S_RULE && mode[1] && (len < sfr_pkg::SFR_LEN_MIN || len > sfr_pkg::SFR_LEN_MAX))
         |=> st_ff == sfr_pkg::SFR_S_FILT;
   endproperty
   a_len_guard: assert property (p_len_guard) else $error("bad pattern length matched");

   property p_event_hold;
      @(posedge i_clk) disable iff (!i_resetn)
      (evt_valid_ff && !evt_pop) |=> evt_valid_ff && $stable(evt_rd_ff);
   endproperty
   a_event_hold: assert property (p_event_hold) else $error("unread event lost");

   property p_cmd_refused;
      @(posedge i_clk) disable iff (!i_resetn)
      (st_ff != sfr_pkg::SFR_S_IDLE && !pkt_done) |=> $stable(cmd_cnt_ff);
   endproperty
   a_cmd_refused: assert property (p_cmd_refused) else $error("command taken while busy");
endmodule
`default_nettype wire

// ---- include/sfr_pkg.sv ----
package sfr_pkg;
   // Rule memory geometry
   localparam int unsigned SFR_MEM_WORDS  = 2048;
   localparam int unsigned SFR_PTR_W      = 11;
   localparam int unsigned SFR_AW         = 12;
   localparam int unsigned SFR_DW         = 32;
   localparam int unsigned SFR_MAX_FILT   = 128;
   localparam int unsigned SFR_IDX_W      = 8;
   localparam int unsigned SFR_FLT_W      = 7;
   localparam int unsigned SFR_EN_WORDS   = 4;
   // Command/event packet: 5 entries of 64 bits as 10 words
   localparam int unsigned SFR_PKT_WORDS  = 10;
   localparam int unsigned SFR_HDR_BASE   = 2;
   localparam int unsigned SFR_HDR_W      = 256;
   localparam logic [3:0]  SFR_PKT_LAST   = 4'h9;
   // Register map (word addresses)
   localparam logic [11:0] SFR_ADDR_CMD   = 12'h800;
   localparam logic [11:0] SFR_ADDR_EVT   = 12'h801;
   localparam logic [11:0] SFR_ADDR_STAT  = 12'h802;
   localparam logic [11:0] SFR_ADDR_EN0   = 12'h804;
   // Descriptor word zero / one
   localparam int unsigned SFR_D0_SINGLE  = 0;
   localparam int unsigned SFR_D0_SIDCHK  = 1;
   localparam int unsigned SFR_D0_TBLCHK  = 2;
   localparam int unsigned SFR_D0_PTR     = 3;
   localparam int unsigned SFR_D1_SID     = 0;
   localparam int unsigned SFR_D1_TBL     = 16;
   // Command word zero
   localparam int unsigned SFR_C_SID      = 0;
   localparam int unsigned SFR_C_TBL      = 16;
   localparam int unsigned SFR_C_MATCH    = 24;
   localparam int unsigned SFR_C_FLT      = 25;
   // Rule control word
   localparam int unsigned SFR_R_BYTE     = 0;
   localparam int unsigned SFR_R_BIT      = 5;
   localparam int unsigned SFR_R_HALT     = 8;
   localparam int unsigned SFR_R_LAST     = 9;
   localparam int unsigned SFR_R_NEXT     = 10;
   localparam int unsigned SFR_R_MODE     = 21;
   localparam int unsigned SFR_R_LEN      = 23;
   localparam logic [3:0]  SFR_LEN_MIN    = 4'h1;
   localparam logic [3:0]  SFR_LEN_MAX    = 4'h4;
   // Rule modes
   localparam logic [1:0]  SFR_MODE_INSIDE  = 2'h0;
   localparam logic [1:0]  SFR_MODE_OUTSIDE = 2'h1;
   localparam logic [1:0]  SFR_MODE_EQUAL   = 2'h2;
   localparam logic [1:0]  SFR_MODE_DIFFER  = 2'h3;
   // Status word fields
   localparam int unsigned SFR_ST_BUSY    = 0;
   localparam int unsigned SFR_ST_EVT     = 1;
   localparam int unsigned SFR_ST_STATE   = 2;
   localparam int unsigned SFR_ST_IDX     = 4;
   localparam int unsigned SFR_ST_PTR     = 12;

   typedef enum logic [1:0] {SFR_S_IDLE, SFR_S_FILT, SFR_S_RULE, SFR_S_EMIT} sfr_state_t;
endpackage

// ---- verification/sfr_fw_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module sfr_fw_model (
   // Bus side
   input  wire logic        i_clk,
   input  wire logic [31:0] i_rdata,
   output logic      [11:0] o_addr,
   output logic      [31:0] o_wdata,
   output logic             o_wr,
   output logic             o_rd
);
   initial begin
      o_addr  = 12'h000;
      o_wdata = 32'h0;
      o_wr    = 1'b0;
      o_rd    = 1'b0;
   end

   // Single-cycle strobes; a gap cycle between calls avoids double assignment
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge i_clk);
      o_addr  <= a;
      o_wdata <= d;
      o_wr    <= 1'b1;
      @(posedge i_clk);
      o_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd   <= 1'b1;
      @(posedge i_clk);
      o_rd   <= 1'b0;
      @(negedge i_clk);
      d = i_rdata;
   endtask
endmodule
`default_nettype wire

// ---- verification/test_section_filter_rule_engine.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_section_filter_rule_engine;
   localparam int unsigned NF = 4;
   logic        i_clk;
   logic        i_resetn;
   logic [11:0] addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        rd_q;
   logic [63:0] exp_q[$];
   logic [63:0] e;
   logic [31:0] hdr[8];
   logic [31:0] d;
   logic [31:0] v;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] c0;
   logic [7:0]  sh;
   logic [1:0]  md;
   int          error_cnt;
   int          compares;

   sfr_rule_engine #(.NUM_FILTERS(NF)) sfr_rule_engine_inst (
      .i_clk(i_clk), .i_resetn(i_resetn), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
   sfr_fw_model sfr_fw_model_inst (
      .i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
      .o_wr(wr), .o_rd(rd));

   initial i_clk = 1'b0;
   always #50 i_clk = ~i_clk;

   // Every read carries a note; a zero mask marks a poll with nothing to check
   always @(posedge i_clk) rd_q <= rd;
   task automatic compare_rdata(input logic [63:0] n);
      compares++;
      if ((rdata & n[31:0]) !== n[63:32]) begin
         error_cnt++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, n[63:32], rdata & n[31:0]);
      end
   endtask

   always @(negedge i_clk) begin
      if (rd_q && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         if (e[31:0] != 32'h0) compare_rdata(e);
      end
   end

   // Let the last read's compare run first; an unchecked note is an error
   task automatic report_and_stop();
      @(posedge i_clk);
      if (exp_q.size() != 0) error_cnt++;
      $display("errors=%0d compares=%0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic rdc(input logic [11:0] ad, input logic [31:0] ex, input logic [31:0] m);
      exp_q.push_back({ex & m, m});
      sfr_fw_model_inst.rd(ad, d);
   endtask

   // Header word k holds bytes 4k..4k+3, lowest byte in bits 7:0
   function automatic logic [31:0] sel(input logic [7:0] s, input logic usebit);
      logic [255:0] h;
      h = {hdr[7], hdr[6], hdr[5], hdr[4], hdr[3], hdr[2], hdr[1], hdr[0]};
      h = h >> (8 * s[4:0] + (usebit ? s[7:5] : 3'h0));
      return h[31:0];
   endfunction

   function automatic logic ev(input logic [1:0] m, input logic [31:0] x);
      case (m)
         2'h0: return a <= x && x <= b;
         2'h1: return x < a || x > b;
         2'h2: return (x & b) == (a & b);
         default: return (x & b) != (a & b);
      endcase
   endfunction

   // Control word, then bounds or coefficient and mask; halt flag left clear
   task automatic rule(input logic [10:0] p, input logic [1:0] m, input logic [7:0] s, input logic last,
                       input logic [10:0] nx, input logic [31:0] lo, input logic [31:0] hi);
      sfr_fw_model_inst.wr({1'b0, p}, {5'h0, 4'h1, m, nx, last, 1'b0, s});
      sfr_fw_model_inst.wr({1'b0, p + 11'h1}, lo);
      sfr_fw_model_inst.wr({1'b0, p + 11'h2}, hi);
   endtask

   task automatic send(input logic [31:0] w0, input logic [31:0] w1, input logic m, input logic [6:0] f);
      int n;
      sfr_fw_model_inst.wr(sfr_pkg::SFR_ADDR_CMD, w0);
      sfr_fw_model_inst.wr(sfr_pkg::SFR_ADDR_CMD, w1);
      for (int k = 0; k < 8; k++) sfr_fw_model_inst.wr(sfr_pkg::SFR_ADDR_CMD, hdr[k]);
      repeat (2) @(posedge i_clk);
      n = 0;
      d = 32'h1;
      while (d[0] && !d[1]) begin
         n++;
         if (n > 500) begin
            error_cnt++;
            report_and_stop();
         end
         rdc(sfr_pkg::SFR_ADDR_STAT, 32'h0, 32'h0);
      end
      rdc(sfr_pkg::SFR_ADDR_STAT, {30'h0, m, 1'b0}, 32'h3);
      if (m) begin
         rdc(sfr_pkg::SFR_ADDR_EVT, {f, 1'b1, w0[23:0]}, 32'hffffffff);
         rdc(sfr_pkg::SFR_ADDR_EVT, w1, 32'hffffffff);
         for (int k = 0; k < 8; k++) rdc(sfr_pkg::SFR_ADDR_EVT, hdr[k], 32'hffffffff);
      end
   endtask

   initial begin
      i_resetn = 1'b0;
      error_cnt = 0;
      compares = 0;
      void'($urandom(15591));
      repeat (20) @(posedge i_clk);
      i_resetn <= 1'b1;
      rdc(12'h000, 32'h0, 32'hffffffff);
      rdc(12'h803, 32'h0, 32'hffffffff);
      rdc(sfr_pkg::SFR_ADDR_EN0, 32'h0, 32'hffffffff);
      sfr_fw_model_inst.wr(12'h7ff, 32'h5aa5c33c);
      sfr_fw_model_inst.wr(12'h7fe, 32'h0ff0e11e);
      rdc(12'h7ff, 32'h5aa5c33c, 32'hffffffff);
      rdc(12'h7fe, 32'h0ff0e11e, 32'hffffffff);
      // Software places descriptors and rules itself, only while idle
      sfr_fw_model_inst.wr(12'h004, {18'h0, 11'h100, 3'b000});
      a = 32'h0;
      b = 32'hffffffff;
      rule(11'h108, 2'h0, 8'h00, 1'b1, 11'h0, a, b);
      sfr_fw_model_inst.wr(sfr_pkg::SFR_ADDR_EN0, 32'h4);
      // Chain head varies by mode; its miss must fail the whole chain
      for (int i = 0; i < 24; i++) begin
         md = 2'(i);
         for (int k = 0; k < 8; k++) hdr[k] = $urandom;
         sh = {3'($urandom_range(0, 7)), 5'($urandom_range(0, 28))};
         v = sel(sh, !md[1]);
         if (!md[1]) begin
            a = v - $urandom_range(0, 2);
            b = v + $urandom_range(0, 2) - 1;
         end else begin
            b = $urandom;
            a = i[2] ? v : v ^ (32'h1 << $urandom_range(0, 31));
         end
         rule(11'h100, md, sh, 1'b0, 11'h108, a, b);
         c0 = {8'h0, 24'($urandom)};
         send(c0, $urandom, ev(md, v), 7'd2);
      end
      // Four-word pattern at byte 3: exact, one bit off, then zero length
      for (int j = 0; j < 3; j++) begin
         for (int k = 0; k < 8; k++) hdr[k] = $urandom;
         sfr_fw_model_inst.wr(12'h100, {5'h0, 4'(j == 2 ? 0 : 4), 2'h2, 11'h0, 1'b1, 1'b0, 8'h03});
         for (int k = 0; k < 4; k++) begin
            sfr_fw_model_inst.wr(12'(12'h101 + k),
                                 sel(8'(8'h03 + 4 * k), 1'b0) ^ ((j == 1 && k == 3) ? 32'h8 : 32'h0));
            sfr_fw_model_inst.wr(12'(12'h105 + k), 32'hffffffff);
         end
         send({8'h0, 24'($urandom)}, $urandom, j == 0, 7'd2);
      end
      a = 32'h0;
      b = 32'hffffffff;
      rule(11'h100, 2'h0, 8'h00, 1'b1, 11'h0, a, b);
      sfr_fw_model_inst.wr(12'h002, {18'h0, 11'h100, 3'b010});
      sfr_fw_model_inst.wr(12'h003, {8'h0, 8'h00, 16'h1234});
      sfr_fw_model_inst.wr(12'h004, {18'h0, 11'h100, 3'b101});
      sfr_fw_model_inst.wr(12'h005, {8'h0, 8'h5a, 16'hffff});
      sfr_fw_model_inst.wr(sfr_pkg::SFR_ADDR_EN0, 32'h6);
      send({8'h0, 8'h5a, 16'h1235}, 32'h1, 1'b1, 7'd2);
      rdc(sfr_pkg::SFR_ADDR_EN0, 32'h2, 32'hf);
      send({8'h0, 8'h5a, 16'h1235}, 32'h2, 1'b0, 7'd0);
      sfr_fw_model_inst.wr(sfr_pkg::SFR_ADDR_EN0, 32'h6);
      send({8'h0, 8'h5b, 16'h1235}, 32'h3, 1'b0, 7'd0);
      send({8'h0, 8'h5a, 16'h1234}, 32'h4, 1'b1, 7'd1);
      rdc(sfr_pkg::SFR_ADDR_EN0, 32'h6, 32'hf);
      report_and_stop();
   end
endmodule
`default_nettype wire
